// file: cwsp_pkg.sv
// constants and types for the configuration word self-programming sequencer
`default_nettype none
package cwsp_pkg;
	// register indices on the plain register port
	localparam logic [3:0]  IDX_PROG_CONTROL = 4'h0;
	localparam logic [3:0]  IDX_UNLOCK_KEY   = 4'h1;
	localparam logic [3:0]  IDX_TABLE_PAGE   = 4'h2;
	localparam logic [3:0]  IDX_TABLE_OFFSET = 4'h3;
	localparam logic [3:0]  IDX_TABLE_STORE  = 4'h4;
	localparam logic [3:0]  IDX_CFG_READBACK = 4'h5;
	localparam logic [3:0]  IDX_IRQ_STATUS   = 4'h6;
	localparam logic [3:0]  IDX_IRQ_MASK     = 4'h7;

	// program_control field positions
	localparam int          BIT_START        = 15;
	localparam int          BIT_PERMIT       = 14;
	localparam int          BIT_FAULT        = 13;
	localparam int          BIT_ERASE        = 6;
	localparam int          OP_MSB           = 3;
	// bit 7 of the page is bit 23 of the table address
	localparam int          BIT_CFG_SPACE    = 7;

	// interrupt status bits
	localparam int          IRQ_DONE         = 0;
	localparam int          IRQ_FAULT        = 1;
	localparam int          IRQ_BITS         = 2;

	localparam logic [15:0] RST_WORD         = 16'h0000;
	localparam logic [7:0]  KEY_FIRST        = 8'h0055;
	localparam logic [7:0]  KEY_SECOND       = 8'h00AA;
	localparam logic [3:0]  OP_CFG_WRITE     = 4'h0;
	localparam logic [15:0] CTRL_CFG_WRITE   = 16'h4000;

	// write duration of one configuration word
	localparam int          CLK_PERIOD_NS    = 50;
	localparam int          WRITE_TIME_NS    = 1000;
	localparam int          WRITE_CYCLES     = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W            = 8;

	typedef enum logic [1:0] {CWSP_KEY_IDLE, CWSP_KEY_HALF, CWSP_KEY_OPEN} cwsp_key_t;
endpackage : cwsp_pkg
`default_nettype wire

// file: cwsp_mem_if.sv
// carrier between the sequencer and its configuration word store
`default_nettype none
interface cwsp_mem_if #(parameter int AW = 4, parameter int DW = 16);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cwsp_mem_if
`default_nettype wire

// file: cwsp_cfg_mem.sv
// configuration word store with registered read data
`default_nettype none
module cwsp_cfg_mem #(
	parameter int AW = 4,
	parameter int DW = 16
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	// store port
	cwsp_mem_if.mem   m
);
	import cwsp_pkg::*;

	generate
		if (AW < 1 || AW > 15 || DW < 1)
			$error("cwsp_cfg_mem: AW must be 1 to 15 and DW positive");
	endgenerate

	logic [DW-1:0] word [2**AW];

	// words are overwritten directly, no erase step in between
	always_ff @(posedge i_mclk)
	begin
		if (m.wr_en)
			word[m.wr_addr] <= m.wr_data;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			m.rd_data <= '0;
		else
			m.rd_data <= word[m.rd_addr];
	end
endmodule : cwsp_cfg_mem
`default_nettype wire

// file: cwsp_top.sv
// configuration word self-programming sequencer with register port
`default_nettype none
// Functional notes
// - each config word is rewritten on its own, no erase before writing
// - only the low word is stored; upper eight bits do not exist
// - table address bit 23 must be set to reach configuration space
// - config write selected by loading program_control with 0x4000
// - key 0x55 then 0xAA, uninterrupted, before start can take effect
// - write begins when bit 15 of program_control is set after unlock
// - processor is stalled while the write runs, resumes when done
// - program_control fields: start 15, permit 14, fault 13, erase 6, op 3:0
// - program_control and unlock_key reset to zero on every reset
// - unimplemented bits of both registers read as zero
// - config writing optional; supported operation codes are implementation dependent
module cwsp_top #(
	parameter int       AW          = 4,
	parameter bit       HAS_CFG_WR  = 1'b1
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// system status and control
	input  wire logic        i_clk_is_frc,
	output logic             o_cpu_stall,
	output logic             o_irq
);
	import cwsp_pkg::*;

	localparam int WC_M1 = WRITE_CYCLES - 1;

	generate
		if (AW < 1 || AW > 15)
			$error("cwsp_top: AW must be 1 to 15");
		if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2**CNT_W)
			$error("cwsp_top: write count does not fit counter");
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic                 busy;
	logic                 permit;
	logic                 fault;
	logic                 erase_sel;
	logic [OP_MSB:0]      op_sel;
	cwsp_key_t            key_state;
	logic [7:0]           table_page;
	logic [15:0]          table_offset;
	logic [15:0]          latch_data;
	logic [7:0]           latch_page;
	logic [AW-1:0]        latch_index;
	logic [IRQ_BITS-1:0]  irq_status;
	logic [IRQ_BITS-1:0]  irq_mask;
	logic [CNT_W-1:0]     cnt;
	logic                 mem_wr;

	logic                 wr_ctrl;
	logic                 start_req;
	logic                 start_ok;
	logic                 start_bad;
	logic                 done_evt;
	logic [IRQ_BITS-1:0]  irq_evt;

	cwsp_mem_if #(.AW(AW), .DW(16)) mif ();

	cwsp_cfg_mem #(.AW(AW), .DW(16)) u_mem (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.m        (mif.mem)
	);

	assign wr_ctrl   = i_wr && (i_addr == IDX_PROG_CONTROL) && !busy;
	assign start_req = wr_ctrl && i_wdata[BIT_START];
	// the key must be open and permit given in this same write
	assign start_ok  = start_req && (key_state == CWSP_KEY_OPEN) && i_wdata[BIT_PERMIT];
	// unsupported op, wrong space or wrong clock aborts with the fault flag
	assign start_bad = start_ok && (!HAS_CFG_WR || i_wdata[OP_MSB:0] != OP_CFG_WRITE
		|| !latch_page[BIT_CFG_SPACE] || !i_clk_is_frc);
	assign done_evt  = busy && (cnt == CNT_W'(WC_M1));
	assign irq_evt   = {start_bad, done_evt};

	////////////////////////////////////////////////////////////////////////////
	// unlock key sequencer

	// any write other than the expected key breaks the sequence, except a repeated 0x55, which keeps the first half
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			key_state <= CWSP_KEY_IDLE;
		else if (i_wr)
		begin
			case (key_state)
				CWSP_KEY_IDLE:
					if (i_addr == IDX_UNLOCK_KEY && i_wdata[7:0] == KEY_FIRST)
						key_state <= CWSP_KEY_HALF;
				CWSP_KEY_HALF:
					if (i_addr == IDX_UNLOCK_KEY && i_wdata[7:0] == KEY_SECOND)
						key_state <= CWSP_KEY_OPEN;
					else if (i_addr == IDX_UNLOCK_KEY && i_wdata[7:0] == KEY_FIRST)
						key_state <= CWSP_KEY_HALF;
					else
						key_state <= CWSP_KEY_IDLE;
				CWSP_KEY_OPEN:
					key_state <= CWSP_KEY_IDLE;
				default:
					key_state <= CWSP_KEY_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program_control

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			permit    <= 1'b0;
			erase_sel <= 1'b0;
			op_sel    <= '0;
		end
		else if (wr_ctrl)
		begin
			permit    <= i_wdata[BIT_PERMIT];
			erase_sel <= i_wdata[BIT_ERASE];
			op_sel    <= i_wdata[OP_MSB:0];
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			fault <= 1'b0;
		else if (start_bad)
			fault <= 1'b1;
		else if (wr_ctrl)
			fault <= i_wdata[BIT_FAULT];
	end

	////////////////////////////////////////////////////////////////////////////
	// table write latch

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			table_page   <= '0;
			table_offset <= '0;
		end
		else if (i_wr && i_addr == IDX_TABLE_PAGE)
			table_page <= i_wdata[7:0];
		else if (i_wr && i_addr == IDX_TABLE_OFFSET)
			table_offset <= i_wdata;
	end

	// a low-word store captures data and address; no high byte exists
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			latch_data  <= '0;
			latch_page  <= '0;
			latch_index <= '0;
		end
		else if (i_wr && i_addr == IDX_TABLE_STORE && !busy)
		begin
			latch_data  <= i_wdata;
			latch_page  <= table_page;
			latch_index <= table_offset[AW:1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write timer and store access

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			busy <= 1'b0;
			cnt  <= '0;
		end
		else if (start_ok && !start_bad)
		begin
			busy <= 1'b1;
			cnt  <= '0;
		end
		else if (done_evt)
			busy <= 1'b0;
		else if (busy)
			cnt <= cnt + 1'b1;
	end

	// no erase pass: the new word lands straight in the store
	assign mem_wr       = done_evt;
	assign mif.wr_en    = mem_wr;
	assign mif.wr_addr  = latch_index;
	assign mif.wr_data  = latch_data;
	assign mif.rd_addr  = table_offset[AW:1];
	assign o_cpu_stall  = busy;

	////////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	generate
		for (genvar b = 0; b < IRQ_BITS; b++)
		begin : g_irq
			always_ff @(posedge i_mclk or negedge i_arst_n)
			begin
				if (!i_arst_n)
					irq_status[b] <= 1'b0;
				else if (irq_evt[b])
					irq_status[b] <= 1'b1;
				else if (i_wr && i_addr == IDX_IRQ_STATUS && i_wdata[b])
					irq_status[b] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			irq_mask <= '0;
		else if (i_wr && i_addr == IDX_IRQ_MASK)
			irq_mask <= i_wdata[IRQ_BITS-1:0];
	end

	assign o_irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_rdata <= '0;
		else if (i_rd)
		begin
			case (i_addr)
				IDX_PROG_CONTROL:
					o_rdata <= {busy, permit, fault, 6'h00, erase_sel, 2'h0, op_sel};
				IDX_UNLOCK_KEY:
					o_rdata <= RST_WORD;
				IDX_TABLE_PAGE:
					o_rdata <= {8'h00, table_page};
				IDX_TABLE_OFFSET:
					o_rdata <= table_offset;
				IDX_TABLE_STORE:
					o_rdata <= latch_data;
				IDX_CFG_READBACK:
					o_rdata <= mif.rd_data;
				IDX_IRQ_STATUS:
					o_rdata <= {14'h0000, irq_status};
				IDX_IRQ_MASK:
					o_rdata <= {14'h0000, irq_mask};
				default:
					o_rdata <= RST_WORD;
			endcase
		end
		else
			o_rdata <= RST_WORD;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	sequence s_start_taken;
		start_ok && !start_bad;
	endsequence

	sequence s_write_runs;
		(busy throughout ##WC_M1 1) ##1 !busy;
	endsequence

	start_unlock_a: assert property (start_ok |-> key_state == CWSP_KEY_OPEN)
		else $error("start taken without unlock");
	write_length_a: assert property (s_start_taken |=> s_write_runs)
		else $error("write does not last the set count");
	start_cause_a: assert property ($rose(busy) |-> $past(start_req) && $past(i_wdata[BIT_PERMIT]))
		else $error("write began without start and permit");
	bad_start_a: assert property (start_req && !start_ok |=> !busy)
		else $error("ignored start launched a write");
	store_end_a: assert property ($fell(busy) |-> $past(mem_wr))
		else $error("write ended without storing the word");
	store_data_a: assert property (mem_wr |-> mif.wr_data == latch_data && latch_page[BIT_CFG_SPACE])
		else $error("store outside config space or wrong data");
	op_select_a: assert property (s_start_taken |-> i_wdata[OP_MSB:0] == OP_CFG_WRITE)
		else $error("write launched with unsupported operation");
	stall_follow_a: assert property (s_start_taken |=> o_cpu_stall [*8])
		else $error("processor not stalled during write");
	start_read_a: assert property (i_rd && i_addr == IDX_PROG_CONTROL && busy |=> o_rdata[BIT_START])
		else $error("start bit not set while busy");
	key_read_a: assert property (i_rd && i_addr == IDX_UNLOCK_KEY |=> o_rdata == RST_WORD)
		else $error("key register read not zero");
	fault_sets_a: assert property (start_bad |=> fault && irq_status[IRQ_FAULT])
		else $error("aborted start did not flag a fault");
endmodule : cwsp_top
`default_nettype wire

// file: test_config_word_self_program.sv
// self-checking bench for the configuration word self-programming sequencer
`default_nettype none
module test_config_word_self_program import cwsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic        i_mclk;
	logic        i_arst_n;
	logic [3:0]  i_addr;
	logic [15:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [15:0] o_rdata;
	logic        i_clk_is_frc;
	logic        o_cpu_stall;
	logic        o_irq;
	int          n_fail;
	int          n_compared;
	int          stall_cnt;

	cwsp_top #(.AW(4), .HAS_CFG_WR(1'b1)) cwsp_top_inst (
		.i_mclk       (i_mclk),
		.i_arst_n     (i_arst_n),
		.i_addr       (i_addr),
		.i_wdata      (i_wdata),
		.i_wr         (i_wr),
		.i_rd         (i_rd),
		.o_rdata      (o_rdata),
		.i_clk_is_frc (i_clk_is_frc),
		.o_cpu_stall  (o_cpu_stall),
		.o_irq        (o_irq)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// counts edges that see the stall, so its length is judged exactly
	always @(posedge i_mclk)
		if (o_cpu_stall === 1'b1)
			stall_cnt++;

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd_chk

	task automatic setup(input logic [15:0] page, input logic [15:0] data, input logic [3:0] op);
		wr(IDX_TABLE_PAGE, page);
		wr(IDX_TABLE_OFFSET, 16'h0004);
		wr(IDX_TABLE_STORE, data);
		wr(IDX_PROG_CONTROL, CTRL_CFG_WRITE | {12'h000, op});
	endtask : setup

	task automatic start(input logic [15:0] key2, input logic [15:0] ctrl);
		wr(IDX_UNLOCK_KEY, {8'h00, KEY_FIRST});
		wr(IDX_UNLOCK_KEY, key2);
		stall_cnt = 0;
		wr(IDX_PROG_CONTROL, ctrl);
		// two idle bus cycles stand for the no-ops after the start write
		repeat (2) @(posedge i_mclk);
	endtask : start

	task automatic wait_idle;
		int n;
		n = 0;
		while (o_cpu_stall === 1'b1 && n < 100)
		begin
			@(posedge i_mclk);
			n++;
		end
		#1;
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(IDX_PROG_CONTROL, RST_WORD);
		rd_chk(IDX_UNLOCK_KEY, RST_WORD);
		rd_chk(4'h9, 16'h0000);
		chk({14'h0000, o_cpu_stall, o_irq}, 16'h0000);
		// read data stand one cycle only, then fall back to zero
		@(posedge i_mclk);
		#1;
		chk(o_rdata, 16'h0000);
		// start without unlock is ignored; gaps in the register read zero
		wr(IDX_PROG_CONTROL, 16'hFFFF);
		rd_chk(IDX_PROG_CONTROL, 16'h604F);
		wr(IDX_PROG_CONTROL, 16'h0000);
		wr(IDX_UNLOCK_KEY, 16'hFFFF);
		rd_chk(IDX_UNLOCK_KEY, 16'h0000);
	endtask : t_reset

	task automatic t_good(input logic [15:0] data);
		setup(16'h0080, data, OP_CFG_WRITE);
		start({8'h00, KEY_SECOND}, 16'hC000);
		#1;
		chk({15'h0000, o_cpu_stall}, 16'h0001);
		rd_chk(IDX_PROG_CONTROL, 16'hC000);
		wait_idle();
		chk(stall_cnt[15:0], 16'(WRITE_CYCLES));
		rd_chk(IDX_CFG_READBACK, data);
		rd_chk(IDX_TABLE_STORE, data);
		rd_chk(IDX_TABLE_PAGE, 16'h0080);
		rd_chk(IDX_TABLE_OFFSET, 16'h0004);
		rd_chk(IDX_PROG_CONTROL, CTRL_CFG_WRITE);
		rd_chk(IDX_IRQ_STATUS, 16'h0001);
		chk({15'h0000, o_irq}, 16'h0001);
		wr(IDX_IRQ_STATUS, 16'h0001);
		#1;
		chk({15'h0000, o_irq}, 16'h0000);
	endtask : t_good

	// a refused start must leave the stored word and the status alone
	task automatic t_refused(input logic [15:0] key2, input logic [15:0] ctrl,
		input logic [15:0] prev);
		setup(16'h0080, 16'hFFFF, OP_CFG_WRITE);
		start(key2, ctrl);
		repeat (3) @(posedge i_mclk);
		chk(stall_cnt[15:0], 16'h0000);
		rd_chk(IDX_CFG_READBACK, prev);
		rd_chk(IDX_IRQ_STATUS, 16'h0000);
	endtask : t_refused

	task automatic t_fault(input logic [15:0] page, input logic [3:0] op, input logic internal_fast_rc);
		setup(page, 16'h0F0F, op);
		i_clk_is_frc <= internal_fast_rc;
		start({8'h00, KEY_SECOND}, 16'hC000 | {12'h000, op});
		repeat (3) @(posedge i_mclk);
		chk(stall_cnt[15:0], 16'h0000);
		rd_chk(IDX_PROG_CONTROL, 16'h4000 | 16'h2000 | {12'h000, op});
		rd_chk(IDX_IRQ_STATUS, 16'h0002);
		chk({15'h0000, o_irq}, 16'h0001);
		// a masked fault must keep the interrupt low
		wr(IDX_IRQ_MASK, 16'h0001);
		#1;
		chk({15'h0000, o_irq}, 16'h0000);
		wr(IDX_IRQ_MASK, 16'h0003);
		i_clk_is_frc <= 1'b1;
		wr(IDX_PROG_CONTROL, CTRL_CFG_WRITE);
		wr(IDX_IRQ_STATUS, 16'h0002);
	endtask : t_fault

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_arst_n     = 1'b0;
		i_addr       = 4'h0;
		i_wdata      = 16'h0000;
		i_wr         = 1'b0;
		i_rd         = 1'b0;
		i_clk_is_frc = 1'b1;
		n_fail       = 0;
		n_compared   = 0;
		stall_cnt    = 0;
		repeat (16) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		t_reset();
		wr(IDX_IRQ_MASK, 16'h0003);
		rd_chk(IDX_IRQ_MASK, 16'h0003);
		t_good(16'h5A3C);
		t_good(16'h00C3);
		t_refused(16'h00A5, 16'hC000, 16'h00C3);
		t_refused({8'h00, KEY_SECOND}, 16'h8000, 16'h00C3);
		t_fault(16'h0000, OP_CFG_WRITE, 1'b1);
		t_fault(16'h0080, OP_CFG_WRITE, 1'b0);
		t_fault(16'h0080, 4'h3, 1'b1);
		test_done();
	end

	// the whole sequence needs well under a thousand cycles
	initial
	begin
		#(20000 * 50);
		n_fail++;
		test_done();
	end
endmodule : test_config_word_self_program
`default_nettype wire
